// >>> smbcc_asserts.sv
/* assertions on the channel control ports.
   assumes binding into the control module. */
`timescale 1ns/10ps
module smbcc_asserts (
  input wire       clk,
  input wire       sys_rst,
  input wire [7:0] sfr_addr,
  input wire [3:0] sfr_page,
  input wire       sfr_wr,
  input wire [7:0] sfr_wmask,
  input wire [7:0] sfr_wdata,
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire       sfr_rvalid,
  input wire       cfg_master_enable,
  input wire       ev_stop_sent,
  input wire       start_req,
  input wire       stop_req,
  input wire       advance,
  input wire       scl_out,
  input wire       scl_oe
);
  wire hit = sfr_addr == 8'hC0 && sfr_page == 4'hF;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////
  AST_RD_ANS: assert property (sfr_rd && hit |=> sfr_rvalid)
    else $error("read not answered");
  AST_RD_REFUSE: assert property (!(sfr_rd && hit) |=> !sfr_rvalid)
    else $error("stray read valid");
  AST_RD_IDLE: assert property (!sfr_rvalid |-> sfr_rdata == 8'h00)
    else $error("idle read data");
  AST_START: assert property (start_req |-> $past(sfr_wr && hit && sfr_wmask[5]
    && sfr_wdata[5] && cfg_master_enable)) else $error("bad start request");
  AST_STOP_DONE: assert property (ev_stop_sent |=> !stop_req && scl_oe)
    else $error("stop not cleared");
  AST_SCL_LOW: assert property (scl_oe |-> !scl_out)
    else $error("clock not low");
  AST_ADV: assert property (advance |-> $past(scl_oe) && $past(sfr_wmask[0]))
    else $error("advance without clear");
  AST_ADV_ONE: assert property (advance |=> !advance)
    else $error("advance too long");
  AST_SCL_HOLD: assert property (scl_oe && !(sfr_wr && hit && sfr_wmask[0]
    && !sfr_wdata[0]) |=> scl_oe) else $error("clock hold dropped");
  AST_CLR_ADV: assert property (scl_oe && sfr_wr && hit && sfr_wmask[0]
    && !sfr_wdata[0] |=> advance) else $error("clear did not advance");
  cover property (advance);
  cover property (start_req);
  cover property (ev_stop_sent ##1 scl_oe);
endmodule

// >>> smbcc_bus_peer.sv
/* far-side bus peer making start and stop.
   assumes pull-ups; the block only pulls the clock low. */
`timescale 1ns/10ps
module smbcc_bus_peer (
  input  wire scl_oe,
  output wire scl_in,
  output wire sda_in
);
  reg scl_drv = 1'b1;
  reg sda_drv = 1'b1;
  // wired-and, so a stalled block wins the clock
  assign scl_in = scl_drv & ~scl_oe;
  assign sda_in = sda_drv;
  task start_cond;
    begin
      sda_drv = 1'b0;
      #400;
      scl_drv = 1'b0;
      #400;
    end
  endtask
  task stop_cond;
    begin
      sda_drv = 1'b0;
      #400;
      scl_drv = 1'b1;
      #400;
      sda_drv = 1'b1;
      #400;
    end
  endtask
endmodule

// >>> smbcc_channel_control.v
/*
  control and status register of the second serial channel, with bus
  start/stop detection and the clock-stall hold.
  assumes a byte shifter on clk that reports frame events and consumes
  the start, stop, advance and acknowledge outputs; scl/sda are pins.
*/
`timescale 1ns/10ps
`include "smbcc_map.vh"

// Function
// RL1 - register at 0xC0 page F, bit-writable, resets zero
// RL2 - bit 7 reads one while bus master
// RL3 - bit 6 reads one while transmitting
// RL4 - bit 5 reads one after start detected
// RL5 - writing one as master requests start
// RL6 - bit 4 shows slave stop or pending stop
// RL7 - master stop sent after ack, then cleared
// RL8 - bit 2 reads one after arbitration lost
// RL9 - hardware sets interrupt flag, software clears it
// RL10 - flag set holds clock line low, stalled
// RL11 - write zero clears and advances; one forces
// RL12 - flag set at start, stop, byte, arbitration
// RL13 - acknowledge request set on each received byte
// RL14 - ack bit: outgoing as receiver, received as transmitter
// RL15 - clearing without ack write sends nack
// RL16 - writes to read-only bits are ignored
module smbcc_channel_control (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [7:0] sfr_addr,
  input  wire [3:0] sfr_page,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wmask,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  output reg        sfr_rvalid,
  input  wire       cfg_master_enable,
  input  wire       ev_start_sent,
  input  wire       ev_stop_sent,
  input  wire       ev_byte_done,
  input  wire       ev_byte_rx,
  input  wire       ev_ack_in,
  input  wire       ev_ack_val,
  input  wire       ev_arb_lost,
  input  wire       tx_mode,
  output reg        start_req,
  output reg        stop_req,
  output reg        advance,
  output reg        ack_out,
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe,
  input  wire       sda_in
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus condition detection
  reg  [1:0] scl_sync_ff;
  reg  [1:0] sda_sync_ff;
  reg        sda_prev_ff;
  reg        scl_prev_ff;
  // edge logic reads the second stage and its delayed copy, never the first
  wire       bus_start = scl_sync_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_sync_ff[1];
  wire       bus_stop  = scl_sync_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_sync_ff[1];

  always @(posedge clk) begin
    if (sys_rst) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register state
  reg        role_ff;
  reg        dir_ff;
  reg        sta_ff;
  reg        sto_ff;
  reg        ackrq_ff;
  reg        arb_ff;
  reg        ack_ff;
  reg        si_ff;
  // remembers an ack write since the last clear; without one a nack goes out
  reg        ack_written_ff;
  reg        nxt_role;
  reg        nxt_dir;
  reg        nxt_sta;
  reg        nxt_sto;
  reg        nxt_ackrq;
  reg        nxt_arb;
  reg        nxt_ack;
  reg        nxt_si;
  reg        nxt_ack_written;
  reg        nxt_ack_out;
  reg        nxt_advance;
  reg        nxt_start_req;

  // decode needs address and page both; other pages hold other registers
  wire hit     = (sfr_addr == `SMBCC_CTRL_ADDR) && (sfr_page == `SMBCC_CTRL_PAGE); // RL1
  wire wr_hit  = sfr_wr & hit;
  wire w_sta   = wr_hit & sfr_wmask[`SMBCC_BIT_START];
  wire w_sto   = wr_hit & sfr_wmask[`SMBCC_BIT_STOP];
  wire w_ack   = wr_hit & sfr_wmask[`SMBCC_BIT_ACK];
  wire w_si    = wr_hit & sfr_wmask[`SMBCC_BIT_INT];
  wire clr_si  = w_si & ~sfr_wdata[`SMBCC_BIT_INT];
  wire hw_si   = ev_start_sent | ev_stop_sent | ev_byte_done | ev_arb_lost
               | bus_start | (bus_stop & ~role_ff); // RL12
  wire [7:0] cur = {role_ff, dir_ff, sta_ff, sto_ff, ackrq_ff, arb_ff, ack_ff, si_ff};

  always @* begin
    nxt_role        = role_ff;
    // direction lags the shifter by one clock, software sees it late
    nxt_dir         = tx_mode; // RL3
    nxt_sta         = sta_ff;
    nxt_sto         = sto_ff;
    nxt_ackrq       = ackrq_ff;
    nxt_arb         = arb_ff;
    nxt_ack         = ack_ff;
    nxt_si          = si_ff;
    nxt_ack_written = ack_written_ff;
    nxt_ack_out     = ack_out;
    nxt_advance     = 1'b0;
    nxt_start_req   = 1'b0;
    // role, read-only, follows the shifter's own start/stop
    if (ev_start_sent)
      nxt_role = 1'b1; // RL2
    // stop and lost arbitration both hand the bus back
    if (ev_stop_sent | ev_arb_lost)
      nxt_role = 1'b0; // RL2
    // start flag
    if (w_sta) begin
      nxt_sta = sfr_wdata[`SMBCC_BIT_START];
      nxt_start_req = sfr_wdata[`SMBCC_BIT_START] & cfg_master_enable; // RL5
    end
    if (bus_start)
      nxt_sta = 1'b1; // RL4
    // stop flag
    if (w_sto)
      nxt_sto = sfr_wdata[`SMBCC_BIT_STOP] & role_ff; // RL7
    if (ev_stop_sent)
      nxt_sto = 1'b0; // RL7
    if (bus_stop & ~role_ff)
      nxt_sto = 1'b1; // RL6
    // acknowledge value
    if (w_ack) begin
      nxt_ack = sfr_wdata[`SMBCC_BIT_ACK]; // RL14
      nxt_ack_written = 1'b1;
      nxt_ack_out = sfr_wdata[`SMBCC_BIT_ACK];
    end
    if (ev_ack_in)
      nxt_ack = ev_ack_val; // RL14
    // software clear advances the channel
    if (clr_si && si_ff) begin
      nxt_advance = 1'b1; // RL11
      nxt_si = 1'b0; // RL11
      if (ackrq_ff && !ack_written_ff && !w_ack)
        nxt_ack_out = 1'b0; // RL15
      nxt_ackrq = 1'b0;
      nxt_arb = 1'b0;
      nxt_ack_written = 1'b0;
    end else if (clr_si) begin
      nxt_si = 1'b0;
    end
    if (w_si && sfr_wdata[`SMBCC_BIT_INT])
      nxt_si = 1'b1; // RL11
    // hardware sets win over a same-cycle clear
    if (hw_si)
      nxt_si = 1'b1; // RL9
    if (ev_byte_rx)
      nxt_ackrq = 1'b1; // RL13
    if (ev_arb_lost)
      nxt_arb = 1'b1; // RL8
  end

  ////////////////////////////////////////////////////////////////////////
  // flops; read-only bits ignore writes to their own bits; ack request and arbitration lost clear when the flag is cleared
  always @(posedge clk) begin
    if (sys_rst) begin
      {role_ff, dir_ff, sta_ff, sto_ff, ackrq_ff, arb_ff, ack_ff, si_ff} <= `SMBCC_CTRL_RESET; // RL1
      ack_written_ff <= 1'b0;
      ack_out        <= 1'b0;
      advance        <= 1'b0;
      start_req      <= 1'b0;
      stop_req       <= 1'b0;
      scl_out        <= 1'b0;
      scl_oe         <= 1'b0;
      sfr_rdata      <= 8'h00;
      sfr_rvalid     <= 1'b0;
    end else begin
      role_ff        <= nxt_role; // RL16
      dir_ff         <= nxt_dir; // RL16
      sta_ff         <= nxt_sta;
      sto_ff         <= nxt_sto;
      ackrq_ff       <= nxt_ackrq; // RL16
      arb_ff         <= nxt_arb; // RL16
      ack_ff         <= nxt_ack;
      si_ff          <= nxt_si;
      ack_written_ff <= nxt_ack_written;
      ack_out        <= nxt_ack_out;
      advance        <= nxt_advance;
      start_req      <= nxt_start_req;
      stop_req       <= nxt_sto & nxt_role; // RL7
      // pin is open-drain: only the enable moves, the level stays low
      scl_out        <= 1'b0;
      // open-drain hold low while the flag stands
      scl_oe         <= nxt_si; // RL10
      sfr_rvalid     <= sfr_rd & hit;
      // zero outside a read so a stale value never reaches the bus
      if (sfr_rd & hit)
        sfr_rdata <= cur;
      else
        sfr_rdata <= 8'h00;
    end
  end

endmodule

// >>> smbcc_channel_control_tb_top.sv
/* bench for the channel control register.
   assumes the bus peer model and the bound checker. */
`timescale 1ns/10ps
module smbcc_channel_control_tb_top;
  logic       clk = 0;
  logic       sys_rst = 1;
  logic [7:0] sfr_addr = 8'hC0;
  logic [3:0] sfr_page = 4'hF;
  logic       sfr_wr = 0;
  logic       sfr_rd = 0;
  logic [7:0] sfr_wmask = 0;
  logic [7:0] sfr_wdata = 0;
  logic       cfg_master_enable = 0;
  logic       tx_mode = 0;
  logic       ev_ack_val = 1;
  logic [5:0] evs = 0;
  int         fail_count = 0;
  int         total_checks = 0;
  wire        ev_start_sent, ev_stop_sent, ev_byte_done, ev_byte_rx, ev_ack_in, ev_arb_lost;
  wire [7:0]  sfr_rdata;
  wire        sfr_rvalid, start_req, stop_req, advance, ack_out, scl_out, scl_oe, scl_in, sda_in;
  assign {ev_arb_lost, ev_ack_in, ev_byte_rx, ev_byte_done, ev_stop_sent, ev_start_sent} = evs;
  smbcc_channel_control smbcc_channel_control_i (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .sfr_addr          (sfr_addr),
    .sfr_page          (sfr_page),
    .sfr_wr            (sfr_wr),
    .sfr_wmask         (sfr_wmask),
    .sfr_wdata         (sfr_wdata),
    .sfr_rd            (sfr_rd),
    .sfr_rdata         (sfr_rdata),
    .sfr_rvalid        (sfr_rvalid),
    .cfg_master_enable (cfg_master_enable),
    .ev_start_sent     (ev_start_sent),
    .ev_stop_sent      (ev_stop_sent),
    .ev_byte_done      (ev_byte_done),
    .ev_byte_rx        (ev_byte_rx),
    .ev_ack_in         (ev_ack_in),
    .ev_ack_val        (ev_ack_val),
    .ev_arb_lost       (ev_arb_lost),
    .tx_mode           (tx_mode),
    .start_req         (start_req),
    .stop_req          (stop_req),
    .advance           (advance),
    .ack_out           (ack_out),
    .scl_in            (scl_in),
    .scl_out           (scl_out),
    .scl_oe            (scl_oe),
    .sda_in            (sda_in)
  );
  smbcc_bus_peer smbcc_bus_peer_i (
    .scl_oe (scl_oe),
    .scl_in (scl_in),
    .sda_in (sda_in)
  );
  ////////////////////////////////
  task chk(input string n, input [7:0] s, input [7:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input [7:0] m, input [7:0] d);
    @(negedge clk);
    sfr_wr = 1;
    sfr_wmask = m;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 0;
  endtask
  task rd(input [7:0] e);
    @(negedge clk);
    sfr_rd = 1;
    @(negedge clk);
    sfr_rd = 0;
    chk("ctrl", sfr_rvalid ? sfr_rdata : 8'hEE, e);
  endtask
  task ev(input [5:0] v);
    @(negedge clk);
    evs = v;
    @(negedge clk);
    evs = 0;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////
  initial forever #50 clk = ~clk;
  initial begin
    #3_000_000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 0;
    rd(8'h00);
    sfr_page = 4'h0;
    rd(8'hEE);
    sfr_page = 4'hF;
    wr(8'hFF, 8'hFF);
    chk("start", start_req, 0);
    rd(8'h23);
    chk("oe", scl_oe, 1);
    chk("scl", scl_out, 0);
    wr(8'hFF, 8'h00);
    chk("adv", advance, 1);
    rd(8'h00);
    $display("register test done");
    cfg_master_enable = 1;
    tx_mode = 1;
    wr(8'h20, 8'h20);
    chk("start", start_req, 1);
    ev(6'h01);
    rd(8'hE1);
    ev(6'h10);
    rd(8'hE3);
    wr(8'h10, 8'h10);
    chk("stop", stop_req, 1);
    ev(6'h02);
    chk("stop", stop_req, 0);
    ev(6'h20);
    rd(8'h67);
    wr(8'h01, 8'h00);
    rd(8'h62);
    tx_mode = 0;
    for (int i = 0; i < 2; i++) begin
      ev(6'h0C);
      if (i == 0) wr(8'h02, 8'h02);
      if (i == 1) rd(8'h2B);
      wr(8'h01, 8'h00);
      chk("ack", ack_out, (i == 0) ? 8'h01 : 8'h00);
    end
    $display("master test done");
    wr(8'h22, 8'h00);
    smbcc_bus_peer_i.start_cond;
    rd(8'h21);
    wr(8'h01, 8'h00);
    smbcc_bus_peer_i.stop_cond;
    rd(8'h31);
    $display("bus test done");
    finish_test;
  end
endmodule
bind smbcc_channel_control smbcc_asserts smbcc_asserts_i (
  .clk               (clk),
  .sys_rst           (sys_rst),
  .sfr_addr          (sfr_addr),
  .sfr_page          (sfr_page),
  .sfr_wr            (sfr_wr),
  .sfr_wmask         (sfr_wmask),
  .sfr_wdata         (sfr_wdata),
  .sfr_rd            (sfr_rd),
  .sfr_rdata         (sfr_rdata),
  .sfr_rvalid        (sfr_rvalid),
  .cfg_master_enable (cfg_master_enable),
  .ev_stop_sent      (ev_stop_sent),
  .start_req         (start_req),
  .stop_req          (stop_req),
  .advance           (advance),
  .scl_out           (scl_out),
  .scl_oe            (scl_oe)
);

// >>> smbcc_map.vh
/*
  register map and field positions of the second channel control register.
  assumes inclusion by bare name from the channel control module.
*/
`ifndef SMBCC_MAP_VH
`define SMBCC_MAP_VH

`define SMBCC_CTRL_ADDR   8'hC0
`define SMBCC_CTRL_PAGE   4'hF
`define SMBCC_CTRL_RESET  8'h00

`define SMBCC_BIT_ROLE    7
`define SMBCC_BIT_DIR     6
`define SMBCC_BIT_START   5
`define SMBCC_BIT_STOP    4
`define SMBCC_BIT_ACKRQ   3
`define SMBCC_BIT_ARBLOST 2
`define SMBCC_BIT_ACK     1
`define SMBCC_BIT_INT     0

`endif
